// >>> logic/oaf_pkg.sv
package oaf_pkg;

  // Flag register bit positions.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLAG_RESET = 8'h68;
  localparam logic [7:0] FLAG_FIXED = 8'h60;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] DAA_LO = 8'h06;
  localparam logic [7:0] DAA_HI = 8'h60;
  localparam logic [3:0] NIB_NINE = 4'h9;
  localparam int IRQ_SOURCES = 128;
  localparam int IRQ_W = 7;

  typedef enum logic [3:0] {
    OAF_INH   = 4'h0,
    OAF_IMM8  = 4'h1,
    OAF_IMM16 = 4'h2,
    OAF_DIR   = 4'h3,
    OAF_EXT   = 4'h4,
    OAF_IX0   = 4'h5,
    OAF_IX1   = 4'h6,
    OAF_IX2   = 4'h7,
    OAF_IX0P  = 4'h8,
    OAF_IX1P  = 4'h9
  } oaf_mode_t;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_ADD  = 4'h1,
    ALU_ADC  = 4'h2,
    ALU_SUB  = 4'h3,
    ALU_SBC  = 4'h4,
    ALU_SHL  = 4'h5,
    ALU_SHR  = 4'h6,
    ALU_ROL  = 4'h7,
    ALU_ROR  = 4'h8,
    ALU_BTST = 4'h9,
    ALU_DAA  = 4'hA,
    ALU_SEI  = 4'hB,
    ALU_CLI  = 4'hC,
    ALU_TAP  = 4'hD
  } oaf_alu_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OP1  = 2'b01,
    ST_OP2  = 2'b11,
    ST_DONE = 2'b10
  } oaf_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } oaf_instr_t;

  typedef struct packed {
    logic [3:0] nbytes;
    oaf_mode_t  mode;
  } oaf_dec_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] imm;
  } oaf_result_t;

endpackage

// >>> logic/oaf_decode.sv
`timescale 1ns/10ps
module oaf_decode (
  // Opcode in.
  input  wire logic [7:0]       opcode,
  // Decoded mode and operand count out.
  output oaf_pkg::oaf_dec_t     dec
);

  // Mode taken from opcode's upper nibble; each index width has its own.
  always_comb begin
    dec.mode   = oaf_pkg::OAF_INH;
    dec.nbytes = 4'h0;
    unique case (opcode[7:4])
      4'hA: begin
        dec.mode   = oaf_pkg::OAF_IMM8; // [RULE_06]
        dec.nbytes = 4'h1;
      end
      4'h4: begin
        dec.mode   = oaf_pkg::OAF_IMM16; // [RULE_06]
        dec.nbytes = 4'h2;
      end
      4'hB: begin
        dec.mode   = oaf_pkg::OAF_DIR;
        dec.nbytes = 4'h1;
      end
      4'hC: begin
        dec.mode   = oaf_pkg::OAF_EXT;
        dec.nbytes = 4'h2;
      end
      4'hF: dec.mode = oaf_pkg::OAF_IX0; // [RULE_04]
      4'hE: begin
        dec.mode   = oaf_pkg::OAF_IX1; // [RULE_04]
        dec.nbytes = 4'h1;
      end
      4'hD: begin
        dec.mode   = oaf_pkg::OAF_IX2; // [RULE_04]
        dec.nbytes = 4'h2;
      end
      4'h7: dec.mode = oaf_pkg::OAF_IX0P; // [RULE_05]
      4'h6: begin
        dec.mode   = oaf_pkg::OAF_IX1P; // [RULE_05]
        dec.nbytes = 4'h1;
      end
      default: begin
        dec.mode   = oaf_pkg::OAF_INH; // [RULE_07]
        dec.nbytes = 4'h0;
      end
    endcase
  end

endmodule // oaf_decode

// >>> logic/oaf_core.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01: Direct mode: high byte zero, low operand.
// RULE_02: Extended: high byte first, then low.
// RULE_03: Indexed: index pair plus 0/8/16 offset.
// RULE_04: Opcode selects offset width and byte count.
// RULE_05: Post-increment: use index, then increment.
// RULE_06: Immediate: one or two operand bytes.
// RULE_07: Inherent: no operand bytes fetched.
// RULE_08: Addition carry out of bit 7 sets carry.
// RULE_09: Borrow, shifts, rotates, bit tests drive carry.
// RULE_10: Carry from low nibble sets half-carry.
// RULE_11: Decimal adjust uses half-carry and carry.
// RULE_12: Mask set ignores interrupts, clear accepts.
// RULE_13: Up to 128 sources, software trap included.
// RULE_14: Eight-bit flag register: mask plus results.
// RULE_15: Index pair halves accessed separately.
// RULE_16: Reset sets interrupt mask.
module oaf_core (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Instruction from control unit.
  input  wire oaf_pkg::oaf_instr_t  instr,
  input  wire logic                 byte_valid,
  input  wire logic [7:0]           byte_data,
  // Arithmetic operation request.
  input  wire oaf_pkg::oaf_alu_t    alu_op,
  input  wire logic                 alu_go,
  input  wire logic [7:0]           alu_a,
  input  wire logic [7:0]           alu_b,
  input  wire logic [2:0]           bit_sel,
  // Index pair access.
  input  wire logic                 hi_we,
  input  wire logic                 lo_we,
  input  wire logic [7:0]           idx_wdata,
  // Interrupt requests.
  input  wire logic                 irq_req,
  input  wire logic [6:0]           irq_src,
  input  wire logic                 sw_trap,
  // Results.
  output oaf_pkg::oaf_result_t      result,
  output logic                      need_byte,
  output logic [15:0]               index_pair,
  output logic [7:0]                flag_register,
  output logic [7:0]                alu_y,
  output logic                      irq_take,
  output logic [6:0]                irq_vec
);

  typedef struct packed {
    oaf_pkg::oaf_state_t  st;
    oaf_pkg::oaf_mode_t   mode;
    logic [3:0]           left;
    logic [15:0]          opnd;
    oaf_pkg::oaf_result_t res;
    logic                 need;
    logic [15:0]          idx;
    logic [7:0]           flg;
    logic [7:0]           y;
    logic                 take;
    logic [6:0]           vec;
  } oaf_core_t;

  oaf_core_t r;
  oaf_core_t next_r;
  oaf_pkg::oaf_dec_t dec;

  oaf_decode u_dec (
    .opcode (instr.opcode),
    .dec    (dec)
  );

  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [7:0]  corr;
  logic        cin;
  logic [15:0] full;

  always_comb begin
    next_r      = r;
    next_r.take = 1'b0;
    next_r.res.valid = 1'b0;
    cin  = r.flg[oaf_pkg::FLG_C];
    sum9 = 9'h000;
    sum5 = 5'h00;
    corr = 8'h00;
    full = {r.opnd[7:0], byte_data};
    unique case (r.st)
      oaf_pkg::ST_IDLE: begin
        if (instr.valid) begin
          next_r.mode = dec.mode;
          next_r.left = dec.nbytes;
          next_r.opnd = 16'h0000;
          next_r.st   = (dec.nbytes == 4'h0) ? oaf_pkg::ST_DONE
                                             : oaf_pkg::ST_OP1; // [RULE_07]
          next_r.need = (dec.nbytes != 4'h0); // [RULE_04]
        end
      end
      oaf_pkg::ST_OP1, oaf_pkg::ST_OP2: begin
        if (byte_valid) begin
          next_r.opnd = full; // [RULE_02]
          next_r.left = r.left - 4'h1;
          if (r.left == 4'h1) begin
            next_r.st   = oaf_pkg::ST_DONE;
            next_r.need = 1'b0;
          end else begin
            next_r.st = oaf_pkg::ST_OP2;
          end
        end
      end
      oaf_pkg::ST_DONE: begin
        next_r.st        = oaf_pkg::ST_IDLE;
        next_r.res.valid = 1'b1;
        next_r.res.imm   = r.opnd; // [RULE_06]
        next_r.res.addr  = 16'h0000;
        unique case (r.mode)
          oaf_pkg::OAF_DIR:
            next_r.res.addr = {oaf_pkg::ZERO_PAGE, r.opnd[7:0]}; // [RULE_01]
          oaf_pkg::OAF_EXT: next_r.res.addr = r.opnd; // [RULE_02]
          oaf_pkg::OAF_IX0, oaf_pkg::OAF_IX1, oaf_pkg::OAF_IX2:
            next_r.res.addr = r.idx + r.opnd; // [RULE_03]
          oaf_pkg::OAF_IX0P, oaf_pkg::OAF_IX1P: begin
            next_r.res.addr = r.idx + r.opnd; // [RULE_05]
            next_r.idx      = r.idx + oaf_pkg::ONE16; // [RULE_05]
          end
          default: next_r.res.addr = 16'h0000;
        endcase
      end
      default: next_r.st = oaf_pkg::ST_IDLE;
    endcase

    // Separate byte writes of the index pair.
    if (hi_we) next_r.idx[15:8] = idx_wdata; // [RULE_15]
    if (lo_we) next_r.idx[7:0]  = idx_wdata; // [RULE_15]

    if (alu_go) begin
      unique case (alu_op)
        oaf_pkg::ALU_ADD, oaf_pkg::ALU_ADC: begin
          sum9 = {1'b0, alu_a} + {1'b0, alu_b}
               + {8'h00, (alu_op == oaf_pkg::ALU_ADC) & cin};
          sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}
               + {4'h0, (alu_op == oaf_pkg::ALU_ADC) & cin};
          next_r.y = sum9[7:0];
          next_r.flg[oaf_pkg::FLG_C] = sum9[8]; // [RULE_08]
          next_r.flg[oaf_pkg::FLG_H] = sum5[4]; // [RULE_10]
        end
        oaf_pkg::ALU_SUB, oaf_pkg::ALU_SBC: begin
          sum9 = {1'b0, alu_a} - {1'b0, alu_b}
               - {8'h00, (alu_op == oaf_pkg::ALU_SBC) & cin};
          next_r.y = sum9[7:0];
          next_r.flg[oaf_pkg::FLG_C] = sum9[8]; // [RULE_09]
        end
        oaf_pkg::ALU_SHL, oaf_pkg::ALU_ROL: begin
          next_r.y = {alu_a[6:0], (alu_op == oaf_pkg::ALU_ROL) & cin};
          next_r.flg[oaf_pkg::FLG_C] = alu_a[7]; // [RULE_09]
        end
        oaf_pkg::ALU_SHR, oaf_pkg::ALU_ROR: begin
          next_r.y = {(alu_op == oaf_pkg::ALU_ROR) & cin, alu_a[7:1]};
          next_r.flg[oaf_pkg::FLG_C] = alu_a[0]; // [RULE_09]
        end
        oaf_pkg::ALU_BTST: next_r.flg[oaf_pkg::FLG_C] = alu_a[bit_sel]; // [RULE_09]
        oaf_pkg::ALU_DAA: begin
          if (r.flg[oaf_pkg::FLG_H] || (alu_a[3:0] > oaf_pkg::NIB_NINE))
            corr = corr | oaf_pkg::DAA_LO; // [RULE_11]
          if (cin || (alu_a > 8'h99))
            corr = corr | oaf_pkg::DAA_HI; // [RULE_11]
          sum9 = {1'b0, alu_a} + {1'b0, corr};
          next_r.y = sum9[7:0];
          next_r.flg[oaf_pkg::FLG_C] = cin | (alu_a > 8'h99); // [RULE_11]
        end
        oaf_pkg::ALU_SEI: next_r.flg[oaf_pkg::FLG_I] = 1'b1;
        oaf_pkg::ALU_CLI: next_r.flg[oaf_pkg::FLG_I] = 1'b0;
        oaf_pkg::ALU_TAP: next_r.flg = alu_a | oaf_pkg::FLAG_FIXED; // [RULE_14]
        default: next_r.y = r.y;
      endcase
    end

    // Hardware requests gated by the mask; the software trap is not.
    if (sw_trap) begin
      next_r.take = 1'b1; // [RULE_13]
      next_r.vec  = {oaf_pkg::IRQ_W{1'b0}};
      next_r.flg[oaf_pkg::FLG_I] = 1'b1;
    end else if (irq_req && !r.flg[oaf_pkg::FLG_I]) begin
      next_r.take = 1'b1; // [RULE_12]
      next_r.vec  = irq_src; // [RULE_13]
      next_r.flg[oaf_pkg::FLG_I] = 1'b1;
    end

    if (rst) begin
      next_r     = '0;
      next_r.st  = oaf_pkg::ST_IDLE;
      next_r.flg = oaf_pkg::FLAG_RESET; // [RULE_16]
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign result        = r.res;
  assign need_byte     = r.need;
  assign index_pair    = r.idx;
  assign flag_register = r.flg;
  assign alu_y         = r.y;
  assign irq_take      = r.take;
  assign irq_vec       = r.vec;

  a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
    (irq_req && !sw_trap && flag_register[oaf_pkg::FLG_I]) |=> !irq_take)
    else $error("masked interrupt taken"); // [RULE_12]
  a_mask_accepts: assert property (@(posedge clk) disable iff (rst)
    (irq_req && !flag_register[oaf_pkg::FLG_I]) |=> irq_take)
    else $error("unmasked interrupt lost"); // [RULE_12]
  a_reset_mask: assert property (@(posedge clk)
    rst |=> flag_register[oaf_pkg::FLG_I])
    else $error("mask not set by reset"); // [RULE_16]
  a_add_carry: assert property (@(posedge clk) disable iff (rst)
    (alu_go && alu_op == oaf_pkg::ALU_ADD && !sw_trap)
      |=> flag_register[oaf_pkg::FLG_C] == ($past(alu_a) + $past(alu_b) > 255))
    else $error("add carry wrong"); // [RULE_08]
  a_sub_borrow: assert property (@(posedge clk) disable iff (rst)
    (alu_go && alu_op == oaf_pkg::ALU_SUB)
      |=> flag_register[oaf_pkg::FLG_C] == ($past(alu_a) < $past(alu_b)))
    else $error("borrow wrong"); // [RULE_09]
  a_half_carry: assert property (@(posedge clk) disable iff (rst)
    (alu_go && alu_op == oaf_pkg::ALU_ADD)
      |=> flag_register[oaf_pkg::FLG_H]
          == ($past(alu_a[3:0]) + $past(alu_b[3:0]) > 15))
    else $error("half carry wrong"); // [RULE_10]
  a_inherent_none: assert property (@(posedge clk) disable iff (rst)
    (r.st == oaf_pkg::ST_IDLE && instr.valid && dec.nbytes == 4'h0)
      |=> !need_byte ##1 result.valid)
    else $error("inherent fetched bytes"); // [RULE_07]
  a_direct_page: assert property (@(posedge clk) disable iff (rst)
    (result.valid && r.mode == oaf_pkg::OAF_DIR)
      |-> result.addr[15:8] == oaf_pkg::ZERO_PAGE)
    else $error("direct high byte not zero"); // [RULE_01]
  a_post_inc: assert property (@(posedge clk) disable iff (rst || hi_we || lo_we)
    (r.st == oaf_pkg::ST_DONE && r.mode == oaf_pkg::OAF_IX0P)
      |=> index_pair == $past(index_pair) + 16'h0001)
    else $error("index not incremented"); // [RULE_05]

endmodule // oaf_core

// >>> verif/oaf_mem_model.sv
`timescale 1ns/10ps
module oaf_mem_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Operand byte handshake.
  input  wire logic need_byte,
  input  wire logic slow,
  output logic      byte_valid,
  output logic [7:0] byte_data,
  // Bytes handed over so far.
  output int        taken
);
  logic [7:0] q[$];
  logic       ph;
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    taken      = 0;
    ph         = 1'b0;
  end
  // Bytes leave in queue order, high byte first.
  always @(posedge clk) begin
    if (byte_valid && need_byte) begin
      void'(q.pop_front());
      taken++;
    end
    ph = ~ph;
    #1;
    byte_valid = need_byte && !rst && q.size() > 0 && (!slow || ph);
    byte_data  = byte_valid ? q[0] : ~byte_data;
  end
endmodule // oaf_mem_model

// >>> verif/operand_address_and_flags_tb.sv
`timescale 1ns/10ps
module operand_address_and_flags_tb;
  logic                 clk, rst, byte_valid, alu_go, hi_we, lo_we;
  logic                 irq_req, sw_trap, need_byte, irq_take, slow;
  logic [7:0]           byte_data, alu_a, alu_b, idx_wdata;
  logic [7:0]           flag_register, alu_y;
  logic [2:0]           bit_sel;
  logic [6:0]           irq_src, irq_vec;
  logic [15:0]          index_pair;
  oaf_pkg::oaf_instr_t  instr;
  oaf_pkg::oaf_alu_t    alu_op;
  oaf_pkg::oaf_result_t result;
  int                   taken, miscompares, checks;

  oaf_core dut (.clk, .rst, .instr, .byte_valid, .byte_data, .alu_op,
    .alu_go, .alu_a, .alu_b, .bit_sel, .hi_we, .lo_we, .idx_wdata,
    .irq_req, .irq_src, .sw_trap, .result, .need_byte, .index_pair,
    .flag_register, .alu_y, .irq_take, .irq_vec);
  oaf_mem_model mem (.clk, .rst, .need_byte, .slow, .byte_valid,
    .byte_data, .taken);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic [7:0] got, exp, m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run_op(input logic [7:0] op, input int nb,
                        input logic [7:0] b0, b1,
                        input logic [15:0] exp, input int k);
    int t0;
    int n;
    t0 = taken;
    if (nb > 0) mem.q.push_back(b0);
    if (nb > 1) mem.q.push_back(b1);
    instr = '{1'b1, op};
    tick(1);
    instr.valid = 1'b0;
    cmp_b({7'h00, need_byte}, {7'h00, nb > 0}, 8'h01);
    n = 0;
    while (result.valid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    cmp_w(16'(n), (n < 20) ? 16'(n) : 16'hFFFF);
    if (!slow) cmp_w(16'(n), 16'(nb + 1));
    if (k == 0) cmp_w(result.addr, exp);
    if (k == 1) cmp_w(result.imm, exp);
    cmp_w(16'(taken - t0), 16'(nb));
  endtask

  task automatic alu(input oaf_pkg::oaf_alu_t op,
                     input logic [7:0] a, b, y, ym, f, fm);
    alu_op = op;
    alu_a  = a;
    alu_b  = b;
    alu_go = 1'b1;
    tick(1);
    alu_go = 1'b0;
    cmp_b(alu_y, y, ym);
    cmp_b(flag_register, f, fm);
    tick(1);
  endtask

  task automatic wr_idx(input logic h, input logic [7:0] d);
    hi_we     = h;
    lo_we     = !h;
    idx_wdata = d;
    tick(1);
    hi_we = 1'b0;
    lo_we = 1'b0;
    tick(1);
  endtask

  task automatic wait_irq(input logic [6:0] v, input logic tk);
    logic s;
    s = 1'b0;
    repeat (8) begin
      if (irq_take === 1'b1 && !s) begin
        s = 1'b1;
        cmp_b({1'b0, irq_vec}, {1'b0, v}, 8'hFF);
      end
      tick(1);
    end
    cmp_b({7'h00, s}, {7'h00, tk}, 8'h01);
  endtask

  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    {alu_go, hi_we, lo_we, irq_req, sw_trap, slow} = 6'h00;
    {alu_a, alu_b, idx_wdata} = 24'h000000;
    {bit_sel, irq_src} = 10'h000;
    instr = '0;
    alu_op = oaf_pkg::ALU_NONE;
    checks = 0;
    miscompares = 0;
    tick(16);
    rst = 1'b0;
    cmp_b(flag_register, 8'h68, 8'hFF);
    cmp_w(index_pair, 16'h0000);
    tick(1);
    wr_idx(1'b1, 8'h12);
    cmp_w(index_pair, 16'h1200);
    wr_idx(1'b0, 8'hF0);
    cmp_w(index_pair, 16'h12F0);
    run_op(8'h9D, 0, 8'h00, 8'h00, 16'h0000, 2);
    run_op(8'hA6, 1, 8'h5A, 8'h00, 16'h005A, 1);
    run_op(8'h45, 2, 8'h12, 8'h34, 16'h1234, 1);
    run_op(8'hB6, 1, 8'hFF, 8'h00, 16'h00FF, 0);
    run_op(8'hC6, 2, 8'hAB, 8'hCD, 16'hABCD, 0);
    slow = 1'b1;
    run_op(8'hF6, 0, 8'h00, 8'h00, 16'h12F0, 0);
    run_op(8'hE6, 1, 8'hFF, 8'h00, 16'h13EF, 0);
    run_op(8'hD6, 2, 8'h01, 8'h10, 16'h1400, 0);
    run_op(8'h76, 0, 8'h00, 8'h00, 16'h12F0, 0);
    run_op(8'h66, 1, 8'h10, 8'h00, 16'h1301, 0);
    cmp_w(index_pair, 16'h12F2);
    alu(oaf_pkg::ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'hFF, 8'h11, 8'h11);
    alu(oaf_pkg::ALU_ADD, 8'h08, 8'h08, 8'h10, 8'hFF, 8'h10, 8'h11);
    alu(oaf_pkg::ALU_SUB, 8'h05, 8'h06, 8'hFF, 8'hFF, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_SBC, 8'h08, 8'h03, 8'h04, 8'hFF, 8'h00, 8'h01);
    alu(oaf_pkg::ALU_SHL, 8'h81, 8'h00, 8'h02, 8'hFF, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_ADC, 8'h01, 8'h01, 8'h03, 8'hFF, 8'h00, 8'h01);
    alu(oaf_pkg::ALU_SHR, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_ROL, 8'h80, 8'h00, 8'h01, 8'hFF, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_ROR, 8'h02, 8'h00, 8'h81, 8'hFF, 8'h00, 8'h01);
    bit_sel = 3'h2;
    alu(oaf_pkg::ALU_BTST, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_BTST, 8'hFB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    alu(oaf_pkg::ALU_ADD, 8'h09, 8'h08, 8'h11, 8'hFF, 8'h10, 8'h11);
    alu(oaf_pkg::ALU_DAA, 8'h11, 8'h00, 8'h17, 8'hFF, 8'h00, 8'h01);
    alu(oaf_pkg::ALU_ADD, 8'h05, 8'h05, 8'h0A, 8'hFF, 8'h00, 8'h11);
    alu(oaf_pkg::ALU_DAA, 8'h0A, 8'h00, 8'h10, 8'hFF, 8'h00, 8'h01);
    alu(oaf_pkg::ALU_ADD, 8'h90, 8'h90, 8'h20, 8'hFF, 8'h01, 8'h11);
    alu(oaf_pkg::ALU_DAA, 8'h20, 8'h00, 8'h80, 8'hFF, 8'h01, 8'h01);
    alu(oaf_pkg::ALU_TAP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'hFF);
    alu(oaf_pkg::ALU_SEI, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08);
    irq_src = 7'h7F;
    irq_req = 1'b1;
    wait_irq(7'h7F, 1'b0);
    alu(oaf_pkg::ALU_CLI, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08);
    wait_irq(7'h7F, 1'b1);
    cmp_b(flag_register, 8'h08, 8'h08);
    irq_req = 1'b0;
    sw_trap = 1'b1;
    tick(1);
    sw_trap = 1'b0;
    wait_irq(7'h00, 1'b1);
    complete_run();
  end
endmodule // operand_address_and_flags_tb
